// File: svmc_top.sv
`timescale 1ns/1ps
module svmc_top
  import svmc_pkg::*;
#(
  parameter int SETTLE_CYCLES_P = SETTLE_CYCLES
)
(
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              supply_low_i,
  output logic                   comparator_enable_o,
  output logic                   level_select_o,
  output logic                   voltage_detect_reset_o,
  output logic                   voltage_detect_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic       detector_enable_bit;
  logic       detector_reset_mode_bit;
  logic       voltage_level_flag;
  logic       level_sel;
  logic       settled;
  logic       flag_prev;
  logic       crossing;
  mon_state_t state;
  mon_state_t next_state;

  svmc_irq_if irq_bus ();

  wire ctrl_wr  = wr_i && (addr_i == CTRL_OFS);
  wire level_wr = wr_i && (addr_i == LEVEL_SEL_OFS);
  // Lock holds until rstn_i, which this block's own reset request never drives
  wire locked   = detector_reset_mode_bit;

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      detector_enable_bit     <= CTRL_RESET[CTRL_EN_BIT];
      detector_reset_mode_bit <= CTRL_RESET[CTRL_MODE_BIT];
    end
    else if (ctrl_wr && !locked)
    begin
      detector_enable_bit     <= wdata_i[CTRL_EN_BIT];
      detector_reset_mode_bit <= wdata_i[CTRL_MODE_BIT];
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      level_sel <= LEVEL_SEL_RESET[LEVEL_BIT];
    else if (level_wr && !locked)
      level_sel <= wdata_i[LEVEL_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator control and settling

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      comparator_enable_o <= 1'b0;
      level_select_o      <= 1'b0;
    end
    else
    begin
      comparator_enable_o <= detector_enable_bit;
      level_select_o      <= level_sel;
    end
  end

  // Comparator output is not trusted until settled
  svmc_settle_timer #(
    .SETTLE_CYCLES_P (SETTLE_CYCLES_P)
  ) u_settle (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .run_i  (comparator_enable_o),
    .done_o (settled)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      MON_OFF:      if (comparator_enable_o) next_state = MON_SETTLING;
      MON_SETTLING: if (!comparator_enable_o) next_state = MON_OFF;
                    else if (settled) next_state = MON_ACTIVE;
      MON_ACTIVE:   if (!comparator_enable_o) next_state = MON_OFF;
      default:      next_state = MON_OFF;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state <= MON_OFF;
    else
      state <= next_state;
  end

  // Flag follows the comparator while enabled
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      voltage_level_flag <= 1'b0;
    else
      voltage_level_flag <= detector_enable_bit && supply_low_i;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      flag_prev <= 1'b0;
    else
      flag_prev <= voltage_level_flag;
  end

  // Switching the detector off is not a supply crossing
  assign crossing = (state == MON_ACTIVE) && detector_enable_bit
                    && (voltage_level_flag != flag_prev);

  ////////////////////////////////////////////////////////////////////////////
  // Detection outcome

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      voltage_detect_reset_o <= 1'b0;
    else
      voltage_detect_reset_o <= (state == MON_ACTIVE) && detector_reset_mode_bit
                                && voltage_level_flag;
  end

  assign irq_bus.event_set = IRQ_W'(crossing && !detector_reset_mode_bit);
  assign irq_bus.clear_wr  = wr_i && (addr_i == IRQ_STAT_OFS);
  assign irq_bus.mask_wr   = wr_i && (addr_i == IRQ_MASK_OFS);
  assign irq_bus.wdata     = wdata_i[IRQ_W-1:0];

  svmc_irq_unit u_irq (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .bus    (irq_bus.unit)
  );

  assign voltage_detect_irq_o = irq_bus.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= '0;
    else if (rd_i)
    begin
      rdata_o <= '0;
      case (addr_i)
        CTRL_OFS:
        begin
          rdata_o[CTRL_EN_BIT]   <= detector_enable_bit;
          rdata_o[CTRL_MODE_BIT] <= detector_reset_mode_bit;
          rdata_o[CTRL_FLAG_BIT] <= voltage_level_flag;
        end
        LEVEL_SEL_OFS: rdata_o[LEVEL_BIT] <= level_sel;
        IRQ_STAT_OFS:  rdata_o[IRQ_W-1:0] <= irq_bus.status;
        IRQ_MASK_OFS:  rdata_o[IRQ_W-1:0] <= irq_bus.mask;
        STATUS_OFS:
        begin
          rdata_o[STAT_SETTLED_BIT] <= settled;
          rdata_o[STAT_LOCKED_BIT]  <= locked;
        end
        default:       rdata_o <= '0;
      endcase
    end
    else
      rdata_o <= '0;
  end

endmodule

// File: svmc_pkg.sv
package svmc_pkg;

  // Register bus
  localparam int          ADDR_W = 4;
  localparam int          DATA_W = 8;

  localparam logic [3:0]  CTRL_OFS      = 4'h0;
  localparam logic [3:0]  LEVEL_SEL_OFS = 4'h1;
  localparam logic [3:0]  IRQ_STAT_OFS  = 4'h2;
  localparam logic [3:0]  IRQ_MASK_OFS  = 4'h3;
  localparam logic [3:0]  STATUS_OFS    = 4'h4;

  // voltage_detect_control fields
  localparam int          CTRL_EN_BIT   = 7;
  localparam int          CTRL_MODE_BIT = 1;
  localparam int          CTRL_FLAG_BIT = 0;
  // voltage_detect_level_select field
  localparam int          LEVEL_BIT     = 0;
  // Interrupt status / mask fields
  localparam int          IRQ_CROSS_BIT = 0;
  localparam int          IRQ_W         = 1;
  // Status register fields
  localparam int          STAT_SETTLED_BIT = 0;
  localparam int          STAT_LOCKED_BIT  = 1;

  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  LEVEL_SEL_RESET = 8'h00;
  localparam logic [0:0]  IRQ_MASK_RESET  = 1'h0;

  // Timing
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          SETTLE_TIME_US  = 200;
  localparam int          SETTLE_CYCLES   =
    (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SETTLE_CNT_W    = 16;

  typedef enum logic [2:0]
  {
    MON_OFF      = 3'b001,
    MON_SETTLING = 3'b010,
    MON_ACTIVE   = 3'b100
  } mon_state_t;

endpackage

// File: svmc_irq_if.sv
`timescale 1ns/1ps
interface svmc_irq_if;
  import svmc_pkg::*;

  logic [IRQ_W-1:0] event_set;
  logic             clear_wr;
  logic             mask_wr;
  logic [IRQ_W-1:0] wdata;
  logic [IRQ_W-1:0] status;
  logic [IRQ_W-1:0] mask;
  logic             irq;

  modport ctrl
  (
    output event_set, clear_wr, mask_wr, wdata,
    input  status, mask, irq
  );
  modport unit
  (
    input  event_set, clear_wr, mask_wr, wdata,
    output status, mask, irq
  );
endinterface

// File: svmc_settle_timer.sv
`timescale 1ns/1ps
module svmc_settle_timer
  import svmc_pkg::*;
#(
  parameter int SETTLE_CYCLES_P = SETTLE_CYCLES
)
(
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  input  wire logic run_i,
  output logic      done_o
);

  logic [SETTLE_CNT_W-1:0] count;

  // Restarts whenever the comparator is switched off
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      count <= '0;
    else if (!run_i)
      count <= '0;
    else if (!done_o)
      count <= count + SETTLE_CNT_W'(1);
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      done_o <= 1'b0;
    else
      done_o <= run_i && (done_o || (count >= SETTLE_CNT_W'(SETTLE_CYCLES_P - 1)));
  end

endmodule

// File: svmc_irq_unit.sv
`timescale 1ns/1ps
module svmc_irq_unit
  import svmc_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  svmc_irq_if.unit  bus
);

  // Set wins over a simultaneous write-one-to-clear
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      bus.status <= '0;
    else
      bus.status <= (bus.status & ~(bus.clear_wr ? bus.wdata : '0)) | bus.event_set;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      bus.mask <= IRQ_MASK_RESET;
    else if (bus.mask_wr)
      bus.mask <= bus.wdata;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      bus.irq <= 1'b0;
    else
      bus.irq <= |(bus.status & bus.mask);
  end

endmodule

// File: svmc_top_sva.sv
`timescale 1ns/1ps
module svmc_top_sva
  import svmc_pkg::*;
#(
  parameter int SETTLE_CYCLES_P = SETTLE_CYCLES
)
(
  input wire logic              mclk_i,
  input wire logic              rstn_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              supply_low_i,
  input wire logic              comparator_enable_o,
  input wire logic              level_select_o,
  input wire logic              voltage_detect_reset_o,
  input wire logic              voltage_detect_irq_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  logic lk;
  // Shadow of the reset-mode lock
  always_ff @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i)
      lk <= 1'b0;
    else if (wr_i && addr_i == CTRL_OFS && wdata_i[CTRL_MODE_BIT])
      lk <= 1'b1;
  ////////////////////////////////////////////////////////////
  AST_EN_WRITE: assert property (
    wr_i && addr_i == CTRL_OFS && !lk ##1 !wr_i
    |=> comparator_enable_o == $past(wdata_i[CTRL_EN_BIT], 2)) else $error("enable not applied");
  AST_LOCK_HOLD: assert property (
    lk [*2] |=> $stable(comparator_enable_o) && $stable(level_select_o))
    else $error("locked setting changed");
  AST_RST_MODE: assert property (
    !lk [*2] |-> !voltage_detect_reset_o) else $error("reset request outside reset mode");
  AST_RST_CAUSE: assert property (
    $rose(voltage_detect_reset_o) |-> $past(supply_low_i, 2)) else $error("reset without low");
  AST_IRQ_MODE: assert property (
    lk [*3] ##0 !voltage_detect_irq_o && !wr_i && !$past(wr_i) |=> !voltage_detect_irq_o)
    else $error("interrupt in reset mode");
  AST_IRQ_CAUSE: assert property (
    $rose(voltage_detect_irq_o) |-> $past(wr_i, 2) || $past(wr_i, 3)
    || $past(supply_low_i, 3) != $past(supply_low_i, 4)) else $error("interrupt without cause");
  cover property ($rose(voltage_detect_irq_o));
  cover property ($rose(voltage_detect_reset_o));
  cover property (lk && wr_i);
endmodule

bind svmc_top svmc_top_sva #(
  .SETTLE_CYCLES_P (SETTLE_CYCLES_P)
) chk (
  .mclk_i                 (mclk_i),
  .rstn_i                 (rstn_i),
  .addr_i                 (addr_i),
  .wdata_i                (wdata_i),
  .wr_i                   (wr_i),
  .rd_i                   (rd_i),
  .rdata_o                (rdata_o),
  .supply_low_i           (supply_low_i),
  .comparator_enable_o    (comparator_enable_o),
  .level_select_o         (level_select_o),
  .voltage_detect_reset_o (voltage_detect_reset_o),
  .voltage_detect_irq_o   (voltage_detect_irq_o)
);

// File: svmc_top_tb.sv
`timescale 1ns/1ps
module svmc_top_tb;
  import svmc_pkg::*;
  logic       mclk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       supply_low_i = 1'b0;
  logic [7:0] rdata_o;
  logic       en_o;
  logic       lvl_o;
  logic       rst_o;
  logic       irq_o;
  logic [7:0] ctl;
  logic [7:0] lvl;
  logic       lk;
  int         err_count = 0;
  int         n_compared = 0;
  svmc_top #(
    .SETTLE_CYCLES_P (8)
  ) dut (
    .mclk_i                 (mclk_i),
    .rstn_i                 (rstn_i),
    .addr_i                 (addr_i),
    .wdata_i                (wdata_i),
    .wr_i                   (wr_i),
    .rd_i                   (rd_i),
    .rdata_o                (rdata_o),
    .supply_low_i           (supply_low_i),
    .comparator_enable_o    (en_o),
    .level_select_o         (lvl_o),
    .voltage_detect_reset_o (rst_o),
    .voltage_detect_irq_o   (irq_o)
  );
  always #10 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pin(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    if (!lk && a == CTRL_OFS)
      ctl = v & 8'h82;
    if (!lk && a == LEVEL_SEL_OFS)
      lvl = v & 8'h01;
    lk = ctl[1];
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic rst();
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;
    ctl = 8'h00;
    lvl = 8'h00;
    lk = 1'b0;
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    err_count++;
    close_out();
  end
  initial
  begin
    void'($urandom(31880));
    rst();
    for (int a = 0; a < 6; a++)
      rd(4'(a), 8'h00);
    wr(CTRL_OFS, 8'h80);
    @(posedge mclk_i);
    #1 pin(en_o, 1'b1);
    repeat (4)
    begin
      wr(LEVEL_SEL_OFS, {7'h00, 1'($urandom)});
      @(posedge mclk_i);
      #1 pin(lvl_o, lvl[0]);
      rd(LEVEL_SEL_OFS, lvl);
    end
    repeat (12) @(posedge mclk_i);
    rd(STATUS_OFS, 8'h01);
    $display("enable test done");
    for (int i = 0; i < 3; i++)
    begin
      wr(IRQ_MASK_OFS, {7'h00, i != 2});
      @(posedge mclk_i);
      supply_low_i <= ~supply_low_i;
      repeat (4) @(posedge mclk_i);
      #1 pin(irq_o, i != 2);
      rd(CTRL_OFS, ctl | {7'h00, supply_low_i});
      rd(IRQ_STAT_OFS, 8'h01);
      wr(IRQ_STAT_OFS, 8'h01);
      @(posedge mclk_i);
      #1 pin(irq_o, 1'b0);
    end
    $display("interrupt test done");
    // Switch off while supply is low, unmasked: no interrupt may follow
    wr(IRQ_MASK_OFS, 8'h01);
    wr(CTRL_OFS, 8'h00);
    repeat (4) @(posedge mclk_i);
    #1 pin(irq_o, 1'b0);
    pin(en_o, 1'b0);
    wr(CTRL_OFS, 8'h80);
    repeat (12) @(posedge mclk_i);
    rd(IRQ_STAT_OFS, 8'h00);
    $display("disable test done");
    wr(CTRL_OFS, 8'h82);
    wr(CTRL_OFS, 8'h00);
    wr(LEVEL_SEL_OFS, {7'h00, ~lvl[0]});
    @(posedge mclk_i);
    #1 pin(en_o, 1'b1);
    pin(lvl_o, lvl[0]);
    pin(rst_o, 1'b1);
    pin(irq_o, 1'b0);
    rd(CTRL_OFS, 8'h83);
    rd(LEVEL_SEL_OFS, lvl);
    rd(STATUS_OFS, 8'h03);
    @(posedge mclk_i);
    supply_low_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    #1 pin(rst_o, 1'b0);
    pin(irq_o, 1'b0);
    rd(IRQ_STAT_OFS, 8'h00);
    rst();
    wr(CTRL_OFS, 8'h80);
    repeat (12) @(posedge mclk_i);
    rd(CTRL_OFS, 8'h80);
    $display("lock test done");
    close_out();
  end
endmodule
